// File: rtl/evt_timebase_pkg.sv
`default_nettype none

package evt_timebase_pkg;

  // Register byte addresses on the APB side.
  localparam logic [31:0] ENABLE_OFFSET  = 32'h0001_d30c;
  localparam logic [31:0] DIVIDER_OFFSET = 32'h0001_d320;

  // Event positions, numbered with position 0 as the word's most significant bit.
  localparam int SLAVE_REG_WRITE_DONE       = 1;
  localparam int SLAVE_REG_READ_DONE        = 2;
  localparam int SLAVE_XFER_DONE            = 3;
  localparam int DIAG_TIMER_EXPIRED         = 5;
  localparam int DIAG_HISTORY_FILLING       = 6;
  localparam int DIAG_COMMAND_DONE          = 7;
  localparam int INBOX_WRITTEN              = 8;
  localparam int OUTBOX_READ                = 9;
  localparam int SLAVE_COLLISION            = 11;
  localparam int SLAVE_XFER_TIMEOUT         = 12;
  localparam int SLAVE_BYTE_TIMEOUT         = 13;
  localparam int SLAVE_CLOCK_LOW_TIMEOUT    = 14;
  localparam int MASTER_XFER_DONE           = 17;
  localparam int BOOT_LOAD_TIMEOUT          = 19;
  localparam int BOOT_LOAD_ERROR            = 20;
  localparam int BOOT_LOAD_SIZE_ERROR       = 21;
  localparam int BOOT_LOAD_NO_DEVICE        = 22;
  localparam int BOOT_LOAD_SUCCESS          = 23;
  localparam int MASTER_NACK_RECEIVED       = 26;
  localparam int MASTER_COLLISION           = 27;
  localparam int MASTER_XFER_TIMEOUT        = 28;
  localparam int MASTER_BYTE_TIMEOUT        = 29;
  localparam int MASTER_CLOCK_LOW_TIMEOUT   = 30;
  localparam int MASTER_ARBITRATION_TIMEOUT = 31;

  // Turns a most-significant-first position into a one-hot word.
  function automatic logic [31:0] doc_bit(input int n);
    return 32'h8000_0000 >> n;
  endfunction

  // The two diagnostic enables that come up masked.
  localparam logic [31:0] DIAG_MASK = doc_bit(DIAG_HISTORY_FILLING) | doc_bit(DIAG_COMMAND_DONE);

  // Every implemented enable; all other positions are reserved.
  localparam logic [31:0] ENABLE_WMASK =
    doc_bit(SLAVE_REG_WRITE_DONE) | doc_bit(SLAVE_REG_READ_DONE) | doc_bit(SLAVE_XFER_DONE) |
    doc_bit(DIAG_TIMER_EXPIRED) | DIAG_MASK | doc_bit(INBOX_WRITTEN) | doc_bit(OUTBOX_READ) |
    doc_bit(SLAVE_COLLISION) | doc_bit(SLAVE_XFER_TIMEOUT) | doc_bit(SLAVE_BYTE_TIMEOUT) |
    doc_bit(SLAVE_CLOCK_LOW_TIMEOUT) | doc_bit(MASTER_XFER_DONE) | doc_bit(BOOT_LOAD_TIMEOUT) |
    doc_bit(BOOT_LOAD_ERROR) | doc_bit(BOOT_LOAD_SIZE_ERROR) | doc_bit(BOOT_LOAD_NO_DEVICE) |
    doc_bit(BOOT_LOAD_SUCCESS) | doc_bit(MASTER_NACK_RECEIVED) | doc_bit(MASTER_COLLISION) |
    doc_bit(MASTER_XFER_TIMEOUT) | doc_bit(MASTER_BYTE_TIMEOUT) |
    doc_bit(MASTER_CLOCK_LOW_TIMEOUT) | doc_bit(MASTER_ARBITRATION_TIMEOUT);

  // Reset values of the two registers.
  localparam logic [31:0] ENABLE_RESET  = 32'h74de_5f3f;
  localparam logic [31:0] DIVIDER_RESET = 32'h0063_03e7;

  // Writable bits of the divider register: the two 12-bit fields.
  localparam logic [31:0] DIVIDER_WMASK = 32'h0fff_0fff;

  // Width of each divider field.
  localparam int DIV_W = 12;

  // Divider register layout; the first member is the most significant.
  typedef struct packed {
    logic [3:0]       rsv_hi;
    logic [DIV_W-1:0] microsecond_divider;
    logic [3:0]       rsv_lo;
    logic [DIV_W-1:0] millisecond_divider;
  } divider_reg_t;

  // The two slow ticks that the controller's timers count.
  typedef struct packed {
    logic us;
    logic ms;
  } tick_t;

  // Register selected by an APB address.
  typedef enum logic [1:0] {SEL_NONE, SEL_ENABLE, SEL_DIVIDER} reg_sel_t;

endpackage

`default_nettype wire

// File: rtl/tick_divider.sv
`timescale 1ns/1ps
`default_nettype none

// Counts advance strobes and emits one tick per (limit + 1) of them.
module tick_divider #(
  parameter int W = 12
) (
  // Clock and reset.
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Count strobe and terminal value.
  input  wire logic         advance,
  input  wire logic [W-1:0] limit,
  // One-cycle tick, registered.
  output logic              tick
);

  // Refuses a counter with no bits while the design is elaborated.
  if (W < 1) begin : g_bad_w
    $error("tick_divider needs W of at least 1");
  end

  logic [W-1:0] count_q;  // Advances seen since the last tick.
  logic         at_end;   // Terminal count reached.

  // Using >= means a limit lowered below the running count wraps at once
  // instead of running through the whole counter range.
  assign at_end = (count_q >= limit);

  // Counter wraps to zero on the advance taken while it stands at the limit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= '0;
    end else if (advance) begin
      count_q <= at_end ? '0 : count_q + W'(1);
    end
  end

  // Tick fires in the cycle after the wrapping advance.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick <= 1'b0;
    end else begin
      tick <= advance && at_end;
    end
  end

endmodule

`default_nettype wire

// File: rtl/event_gate.sv
`timescale 1ns/1ps
`default_nettype none

// Passes each recorded event into interrupt status only where enabled.
module event_gate #(
  parameter int N = 32
) (
  // Clock and reset.
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Recorded events and their enables.
  input  wire logic [N-1:0] events,
  input  wire logic [N-1:0] enables,
  // Gated events, registered.
  output logic      [N-1:0] status
);

  // Refuses an empty event word while the design is elaborated.
  if (N < 1) begin : g_bad_n
    $error("event_gate needs N of at least 1");
  end

  // One flop per event; the events themselves are never altered here.
  for (genvar i = 0; i < N; i++) begin : g_bit
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        status[i] <= 1'b0;
      end else begin
        status[i] <= events[i] & enables[i];
      end
    end
  end

endmodule

`default_nettype wire

// File: rtl/evt_timebase.sv
`timescale 1ns/1ps
`default_nettype none

module evt_timebase #(
  parameter int ADDR_W = 17
) (
  // APB clock and reset.
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB request.
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  // APB answer.
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // Events recorded by the controller's event register.
  input  wire logic [31:0]       event_recorded,
  // Events passed on to interrupt status.
  output logic [31:0]            irq_status_events,
  // Timebase ticks for the controller's timers.
  output evt_timebase_pkg::tick_t ticks
);

  // The highest register offset must fit in the address bus.
  if (ADDR_W < 17 || ADDR_W > 32) begin : g_bad_addr_w
    $error("evt_timebase needs ADDR_W in 17..32");
  end

  // Maps a byte address onto one of the two registers.
  // Only whole-word addresses match; any other address is refused.
  function automatic evt_timebase_pkg::reg_sel_t decode(input logic [31:0] addr);
    if (addr == evt_timebase_pkg::ENABLE_OFFSET) begin
      return evt_timebase_pkg::SEL_ENABLE;
    end else if (addr == evt_timebase_pkg::DIVIDER_OFFSET) begin
      return evt_timebase_pkg::SEL_DIVIDER;
    end
    return evt_timebase_pkg::SEL_NONE;
  endfunction

  // Merges write data by byte lane, touching only writable bits.
  // Lanes without a strobe, and reserved bits, keep their stored value.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdata,
                                        input logic [3:0] strb, input logic [31:0] wmask);
    logic [31:0] lanes;
    lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
    return (old & ~lanes) | (wdata & lanes);
  endfunction

  logic [31:0]                    enable_q;   // Event enable register.
  evt_timebase_pkg::divider_reg_t divider_q;  // Tick divider register.
  evt_timebase_pkg::reg_sel_t     sel;        // Register addressed now.
  logic                           access;     // APB access phase.
  logic                           done;       // Transfer completes this edge.
  logic                           wr_done;    // Write completes this edge.
  logic [31:0]                    rd_value;   // Read mux output.
  logic                           us_tick;    // Microsecond tick flop.
  logic                           ms_tick;    // Millisecond tick flop.

  assign sel     = decode(32'(paddr));
  assign access  = psel && penable;
  assign done    = access && pready;
  assign wr_done = done && pwrite;

  // APB answers after one wait state, so every answer comes from a flop.
  // The wait state costs a cycle per access but keeps the address decode
  // and the read mux off the path to the bus outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= access && !pready;
    end
  end

  // Read mux; reserved bits are never stored, so they read as zero.
  // The decode function never yields the fourth code of the select type.
  always_comb begin
    unique case (sel)
      evt_timebase_pkg::SEL_ENABLE: begin
        rd_value = enable_q & evt_timebase_pkg::ENABLE_WMASK;
      end
      evt_timebase_pkg::SEL_DIVIDER: begin
        rd_value = divider_q & evt_timebase_pkg::DIVIDER_WMASK;
      end
      evt_timebase_pkg::SEL_NONE: begin
        rd_value = 32'h0000_0000;
      end
    endcase
  end

  // Read data and error are captured in the first access cycle and stand
  // with pready; an unmapped address answers with an error and zero data.
  // Writes answer with zero data, so the bus never shows a stale value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (access && !pready) begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_value;
      pslverr <= (sel == evt_timebase_pkg::SEL_NONE);
    end else begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // Enable register; reserved positions ignore writes.
  // The two diagnostic enables in DIAG_MASK come up clear, so those events stay masked.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= evt_timebase_pkg::ENABLE_RESET;
    end else if (wr_done && sel == evt_timebase_pkg::SEL_ENABLE) begin
      enable_q <= merge(enable_q, pwdata, pstrb, evt_timebase_pkg::ENABLE_WMASK);
    end
  end

  // Divider register; a new value takes hold at the next wrap check.
  // Software that lowers a field mid-period sees one short period, never
  // a run through the whole counter range.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divider_q <= evt_timebase_pkg::DIVIDER_RESET;
    end else if (wr_done && sel == evt_timebase_pkg::SEL_DIVIDER) begin
      divider_q <= merge(divider_q, pwdata, pstrb, evt_timebase_pkg::DIVIDER_WMASK);
    end
  end

  // The recorded events are only read here, never cleared, so a masked
  // event still stands in the event register for software to see.
  // Status lags the events by one clock so that it leaves from a flop,
  // a delay that a level-held event never notices.
  event_gate #(
    .N (32)
  ) u_gate (
    .pclk    (pclk),
    .presetn (presetn),
    .events  (event_recorded),
    .enables (enable_q),
    .status  (irq_status_events)
  );

  // Microsecond divider counts every reference clock.
  tick_divider #(
    .W (evt_timebase_pkg::DIV_W)
  ) u_us_div (
    .pclk    (pclk),
    .presetn (presetn),
    .advance (1'b1),
    .limit   (divider_q.microsecond_divider),
    .tick    (us_tick)
  );

  // Millisecond divider counts microsecond ticks, not reference clocks.
  tick_divider #(
    .W (evt_timebase_pkg::DIV_W)
  ) u_ms_div (
    .pclk    (pclk),
    .presetn (presetn),
    .advance (us_tick),
    .limit   (divider_q.millisecond_divider),
    .tick    (ms_tick)
  );

  // Both ticks leave straight from their divider flops.
  // The millisecond tick trails the microsecond tick that wraps it by a clock.
  assign ticks.us = us_tick;
  assign ticks.ms = ms_tick;

  // Helper logic below is read only by the assertions.
  // The gap counters are 13 bits wide so that the longest period, a full
  // 12-bit field plus one, still fits without wrapping.

  logic [12:0] us_gap_q;     // Clocks since the last microsecond tick.
  logic        us_seen_q;    // A microsecond tick has occurred.
  logic        div_wr_q;     // Divider written since the last tick.
  logic [12:0] ms_gap_q;     // Microsecond ticks since the last ms tick.
  logic        ms_seen_q;    // A millisecond tick has occurred.
  logic        ms_div_wr_q;  // Divider written since the last ms tick.
  logic        div_write;    // Divider write this edge.

  assign div_write = wr_done && sel == evt_timebase_pkg::SEL_DIVIDER;

  // Measures the spacing of microsecond ticks while the divider is steady.
  // A divider write skips one check, since the period in flight may be short.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      us_gap_q  <= 13'h0001;
      us_seen_q <= 1'b0;
      div_wr_q  <= 1'b0;
    end else if (us_tick) begin
      us_gap_q  <= 13'h0001;
      us_seen_q <= 1'b1;
      div_wr_q  <= div_write;
    end else begin
      us_gap_q  <= us_gap_q + 13'h0001;
      div_wr_q  <= div_wr_q || div_write;
    end
  end

  // Measures millisecond tick spacing in microsecond ticks.
  // Only microsecond ticks add to the gap, so the check is in those units.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_gap_q    <= 13'h0000;
      ms_seen_q   <= 1'b0;
      ms_div_wr_q <= 1'b0;
    end else if (ms_tick) begin
      ms_gap_q    <= {12'h000, us_tick};
      ms_seen_q   <= 1'b1;
      ms_div_wr_q <= div_write;
    end else begin
      ms_gap_q    <= ms_gap_q + {12'h000, us_tick};
      ms_div_wr_q <= ms_div_wr_q || div_write;
    end
  end

  // Status follows the enabled events one clock later, once out of reset.
  a_mask_blocks_event: assert property (
    @(posedge pclk) disable iff (!presetn)
    presetn |=> (irq_status_events == ($past(event_recorded) & $past(enable_q))))
    else $error("interrupt status does not follow enabled events");

  // Both diagnostic enables in DIAG_MASK must come out of reset clear.
  a_diag_masked_reset: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> ((enable_q & evt_timebase_pkg::DIAG_MASK) == 32'h0000_0000))
    else $error("diagnostic enables not clear after reset");

  // The whole enable word must come out of reset at its reset value.
  a_enable_reset_value: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> (enable_q == evt_timebase_pkg::ENABLE_RESET))
    else $error("enable register reset value wrong");

  // An all-ones write sets exactly the implemented enable positions.
  a_enable_all_ones: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_done && sel == evt_timebase_pkg::SEL_ENABLE && pwdata == 32'hffff_ffff
     && pstrb == 4'hf) |=> (enable_q == evt_timebase_pkg::ENABLE_WMASK))
    else $error("enable positions wrong after all-ones write");

  // Reserved enable positions never show on the bus.
  a_reserved_read_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pready && !pwrite && sel == evt_timebase_pkg::SEL_ENABLE)
      |-> ((prdata & ~evt_timebase_pkg::ENABLE_WMASK) == 32'h0000_0000))
    else $error("reserved enable bits read nonzero");

  // With the divider left alone, microsecond ticks come field plus one clocks apart.
  a_us_tick_period: assert property (
    @(posedge pclk) disable iff (!presetn)
    (us_tick && us_seen_q && !div_wr_q && !div_write)
      |-> (us_gap_q == 13'(divider_q.microsecond_divider) + 13'h0001))
    else $error("microsecond tick spacing wrong");

  // Both divider fields must come out of reset at their reset values.
  a_div_reset_value: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> (divider_q == evt_timebase_pkg::DIVIDER_RESET))
    else $error("divider reset value wrong");

  // A millisecond tick only ever follows a microsecond tick.
  a_ms_follows_us: assert property (
    @(posedge pclk) disable iff (!presetn)
    ticks.ms |-> $past(ticks.us))
    else $error("millisecond tick without a microsecond tick");

  // Millisecond ticks come field plus one microsecond ticks apart.
  a_ms_tick_period: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ms_tick && ms_seen_q && !ms_div_wr_q && !div_write)
      |-> (ms_gap_q == 13'(divider_q.millisecond_divider) + 13'h0001))
    else $error("millisecond tick spacing wrong");

  // With every enable clear, nothing reaches interrupt status.
  a_masked_kept_out: assert property (
    @(posedge pclk) disable iff (!presetn)
    (event_recorded != 32'h0000_0000 && enable_q == 32'h0000_0000)
      |=> (irq_status_events == 32'h0000_0000))
    else $error("masked event reached interrupt status");

  // Each access gets exactly one wait state and a one-cycle pready.
  a_pready_one_cycle: assert property (
    @(posedge pclk) disable iff (!presetn)
    (access && !pready) |=> (pready ##1 !pready))
    else $error("pready not a single-cycle answer");

  // An unmapped word answers with an error after the usual wait state.
  a_unmapped_error: assert property (
    @(posedge pclk) disable iff (!presetn)
    (access && !pready && sel == evt_timebase_pkg::SEL_NONE) |=> (pready && pslverr))
    else $error("unmapped access answered without error");

  // A refused transfer must leave both registers exactly as they were.
  a_unmapped_no_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    (done && sel == evt_timebase_pkg::SEL_NONE) |=> ($stable(enable_q) && $stable(divider_q)))
    else $error("unmapped write changed a register");

  // A full-word enable write keeps exactly the implemented positions.
  a_enable_word_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_done && sel == evt_timebase_pkg::SEL_ENABLE && pstrb == 4'hf)
      |=> (enable_q == ($past(pwdata) & evt_timebase_pkg::ENABLE_WMASK)))
    else $error("enable register write landed wrongly");

  // A full-word divider write keeps only the two divider fields.
  a_divider_word_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_done && sel == evt_timebase_pkg::SEL_DIVIDER && pstrb == 4'hf)
      |=> (divider_q == ($past(pwdata) & evt_timebase_pkg::DIVIDER_WMASK)))
    else $error("divider register write landed wrongly");

  // Read data stands only with pready; the bus sees zero otherwise.
  a_prdata_idle_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    !pready |-> (prdata == 32'h0000_0000))
    else $error("read data present without pready");

  // Leaving reset, neither tick fires before the counters have run.
  a_ticks_quiet_reset: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> (!ticks.us && !ticks.ms))
    else $error("tick present right after reset");

endmodule

`default_nettype wire

// File: sim/evt_timebase_tb.sv
`timescale 1ns/1ps
`default_nettype none

module evt_timebase_tb;
  // Register byte addresses, and one of the unmapped words between them.
  localparam logic [16:0] A_EN  = 17'h1d30c;
  localparam logic [16:0] A_DIV = 17'h1d320;
  localparam logic [16:0] A_GAP = 17'h1d310;
  // Implemented enable positions, position 0 being the most significant bit.
  localparam int          POS [24] = '{1, 2, 3, 11, 12, 13, 14,
                                       5, 6, 7, 8, 9,
                                       17, 26, 27, 28, 29, 30, 31,
                                       19, 20, 21, 22, 23};

  // Design inputs, all driven by this bench.
  logic                     pclk;
  logic                     presetn;
  logic                     psel;
  logic                     penable;
  logic                     pwrite;
  logic [16:0]              paddr;
  logic [31:0]              pwdata;
  logic [3:0]               pstrb;
  logic [31:0]              event_recorded;
  // Design outputs.
  logic                     pready;
  logic [31:0]              prdata;
  logic                     pslverr;
  logic [31:0]              irq_status_events;
  evt_timebase_pkg::tick_t  ticks;
  // Bench bookkeeping and the last bus answer.
  int                       err_total;
  int                       checks;
  int                       cycles;
  logic [31:0]              rd;
  logic                     er;
  logic [31:0]              mask;

  evt_timebase uut (
    .pclk              (pclk),
    .presetn           (presetn),
    .psel              (psel),
    .penable           (penable),
    .pwrite            (pwrite),
    .paddr             (paddr),
    .pwdata            (pwdata),
    .pstrb             (pstrb),
    .pready            (pready),
    .prdata            (prdata),
    .pslverr           (pslverr),
    .event_recorded    (event_recorded),
    .irq_status_events (irq_status_events),
    .ticks             (ticks)
  );

  // The 25 ns clock.
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // A hang ends the run through the same report as a normal finish.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  // Compares one value and counts the outcome.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // One APB transfer; the answer is taken at the edge where pready is seen high.
  task automatic apb(input logic wr, input logic [16:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) check("pready", {31'h0, pready}, 32'h1);
  endtask

  // Counts clocks between two tick pulses, after skipping one to let a new setting settle.
  task automatic tick_period(input logic ms, output int p);
    int n;
    n = 0;
    repeat (2) begin
      do begin
        @(posedge pclk);
        n++;
      end while ((ms ? ticks.ms : ticks.us) !== 1'b1 && n < 400);
    end
    p = 0;
    do begin
      @(posedge pclk);
      p++;
    end while ((ms ? ticks.ms : ticks.us) !== 1'b1 && p < 400);
  endtask

  // Reset values of both registers, with the two diagnostic enables in DIAG_MASK clear.
  task automatic t_reset_values();
    apb(1'b0, A_EN, 32'h0, 4'h0);
    check("enable reset", rd, 32'h74de_5f3f);
    check("diag enables", rd & ((32'h8000_0000 >> 6) | (32'h8000_0000 >> 7)), 32'h0);
    check("enable err", {31'h0, er}, 32'h0);
    apb(1'b0, A_DIV, 32'h0, 4'h0);
    check("divider reset", rd, 32'h0063_03e7);
    check("us field", {20'h0, rd[27:16]}, 32'h63);
    check("ms field", {20'h0, rd[11:0]}, 32'h3e7);
  endtask

  // Writable bits, reserved bits and byte-lane strobes.
  task automatic t_access();
    apb(1'b1, A_EN, 32'hffff_ffff, 4'hf);
    apb(1'b0, A_EN, 32'h0, 4'h0);
    check("enable ones", rd, mask);
    apb(1'b1, A_EN, 32'h0, 4'hf);
    apb(1'b1, A_EN, 32'hffff_ffff, 4'h1);
    apb(1'b0, A_EN, 32'h0, 4'h0);
    check("enable lane0", rd, mask & 32'h0000_00ff);
    apb(1'b1, A_DIV, 32'hffff_ffff, 4'hf);
    apb(1'b0, A_DIV, 32'h0, 4'h0);
    check("divider ones", rd, 32'h0fff_0fff);
    apb(1'b1, A_DIV, 32'h0, 4'hf);
    apb(1'b1, A_DIV, 32'hffff_ffff, 4'h4);
    apb(1'b0, A_DIV, 32'h0, 4'h0);
    check("divider lane2", rd, 32'h00ff_0000);
  endtask

  // An unmapped word is refused and leaves the enable register undisturbed.
  task automatic t_unmapped();
    apb(1'b1, A_GAP, 32'hffff_ffff, 4'hf);
    check("gap write err", {31'h0, er}, 32'h1);
    apb(1'b0, A_GAP, 32'h0, 4'h0);
    check("gap read err", {31'h0, er}, 32'h1);
    check("gap read data", rd, 32'h0);
    apb(1'b0, A_EN, 32'h0, 4'h0);
    check("enable after gap", rd, mask & 32'h0000_00ff);
  endtask

  // Each enable alone lets through exactly its own event.
  task automatic t_gating();
    logic [31:0] one;
    foreach (POS[i]) begin
      one = 32'h8000_0000 >> POS[i];
      apb(1'b1, A_EN, one, 4'hf);
      @(posedge pclk);
      event_recorded <= 32'hffff_ffff;
      repeat (2) @(posedge pclk);
      check("gated one", irq_status_events, one);
      event_recorded <= ~one;
      repeat (2) @(posedge pclk);
      check("gated none", irq_status_events, 32'h0);
    end
    apb(1'b1, A_EN, 32'hffff_ffff, 4'hf);
    event_recorded <= 32'hffff_ffff;
    repeat (2) @(posedge pclk);
    check("gated all", irq_status_events, mask);
  endtask

  // Microsecond tick period at the reset setting, and both tick periods at small and zero divider values.
  task automatic t_ticks();
    int p;
    // Earlier scenarios leave the divider altered, so put the reset setting back.
    apb(1'b1, A_DIV, 32'h0063_03e7, 4'hf);
    tick_period(1'b0, p);
    check("us period reset", p, 32'd100);
    apb(1'b1, A_DIV, 32'h0001_0002, 4'hf);
    tick_period(1'b0, p);
    check("us period 2", p, 32'd2);
    tick_period(1'b1, p);
    check("ms period 6", p, 32'd6);
    apb(1'b1, A_DIV, 32'h0, 4'hf);
    tick_period(1'b0, p);
    check("us period 1", p, 32'd1);
    tick_period(1'b1, p);
    check("ms period 1", p, 32'd1);
  endtask

  // A second reset in mid-run restores both registers and silences outputs.
  task automatic t_rereset();
    apb(1'b1, A_EN, 32'h0, 4'hf);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check("irq in reset", irq_status_events, 32'h0);
    check("ticks in reset", {30'h0, ticks}, 32'h0);
    presetn <= 1'b1;
    t_reset_values();
  endtask

  // Main sequence: reset, then every scenario in turn.
  initial begin
    err_total      = 0;
    checks         = 0;
    cycles         = 0;
    presetn        = 1'b0;
    psel           = 1'b0;
    penable        = 1'b0;
    pwrite         = 1'b0;
    paddr          = 17'h0;
    pwdata         = 32'h0;
    pstrb          = 4'h0;
    event_recorded = 32'hffff_ffff;
    mask           = 32'h0;
    foreach (POS[i]) mask |= 32'h8000_0000 >> POS[i];
    repeat (6) @(posedge pclk);
    check("irq during reset", irq_status_events, 32'h0);
    presetn <= 1'b1;
    t_reset_values();
    t_access();
    t_unmapped();
    t_gating();
    t_ticks();
    t_rereset();
    report_and_stop();
  end
endmodule

`default_nettype wire
